// file: verilog/tlipc_ctrl.sv
// Two-level interrupt priority controller top with its special function registers.
`timescale 1ns/1ns
module tlipc_ctrl (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Special function register port
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // Source events and level flags
  input wire logic [tlipc_pkg::TLIPC_NSRC-1:0] SRC_EVENT,
  input wire logic EXT_PIN_ZERO_N,
  input wire logic EXT_PIN_ONE_N,
  input wire logic TMR2_LOW_OVERFLOW,
  input wire logic TMR2_HIGH_OVERFLOW,
  input wire logic SERIAL_XFER_DONE,
  input wire logic WRITE_COLLISION,
  input wire logic MODE_FAULT,
  input wire logic RECEIVE_OVERRUN,
  // Core sequencer handshake
  input wire logic INSTR_DONE,
  input wire logic IRQ_ACK,
  input wire logic RETURN_FROM_IRQ_DONE,
  output logic IRQ_REQ,
  output logic IRQ_HIGH,
  output logic [tlipc_pkg::TLIPC_OW-1:0] IRQ_ORDER,
  output logic [15:0] IRQ_VECTOR
);
  import tlipc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [TLIPC_NSRC-1:0] map_bits(input logic [7:0] base,
                                                     input logic [7:0] ext1,
                                                     input logic [7:0] ext2);
    logic [TLIPC_NSRC-1:0] v;
    v = '0;
    v[6:0] = base[6:0];
    v[7] = ext1[0];
    v[14:9] = ext1[7:2];
    v[ORD_PORT_MATCH] = ext2[EXT2_PORT_MATCH_BIT];
    return v & SRC_PRESENT;
  endfunction : map_bits

  function automatic logic [TLIPC_NSRC-1:0] below(input logic [TLIPC_OW-1:0] ord);
    below = TLIPC_NSRC'((18'h00001 << ord) - 18'h00001);
  endfunction : below

  logic [7:0] ie_reg, ip_reg, enable_reg_ext_one_reg, priority_reg_ext_one_reg, enable_reg_ext_two_reg, priority_reg_ext_two_reg;
  logic [TLIPC_NSRC-1:0] pend_reg;
  logic [2:0] pin_sync_reg [2];
  logic [1:0] pin_filt_reg;
  logic [1:0] pin_fall;
  logic isr_lo_reg, isr_hi_reg, hold_reg, prio_written_reg;
  logic [TLIPC_NSRC-1:0] en_vec, pr_vec, req_vec, cand, cand_hi, cand_lo;
  logic found_hi, found_lo;
  logic [TLIPC_OW-1:0] idx_hi, idx_lo, sel_idx;
  logic req_next;
  logic [7:0] rdata_next;

  wire logic gate = ie_reg[GLOBAL_IRQ_GATE_BIT];
  wire logic wr_ie = SFR_WR && (SFR_ADDR == IRQ_ENABLE_MASK_ADDR);
  wire logic wr_ip = SFR_WR && (SFR_ADDR == PRIORITY_REG_BASE_ADDR);
  wire logic wr_enable_reg_ext_one = SFR_WR && (SFR_ADDR == ENABLE_REG_EXT_ONE_ADDR);
  wire logic wr_priority_reg_ext_one = SFR_WR && (SFR_ADDR == PRIORITY_REG_EXT_ONE_ADDR);
  wire logic wr_enable_reg_ext_two = SFR_WR && (SFR_ADDR == ENABLE_REG_EXT_TWO_ADDR);
  wire logic wr_priority_reg_ext_two = SFR_WR && (SFR_ADDR == PRIORITY_REG_EXT_TWO_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Enable and priority registers; priorities start low.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ie_reg <= IRQ_ENABLE_MASK_RST;
      enable_reg_ext_one_reg <= IRQ_ENABLE_MASK_RST;
      enable_reg_ext_two_reg <= IRQ_ENABLE_MASK_RST;
    end else begin
      if (wr_ie) ie_reg <= SFR_WDATA;
      if (wr_enable_reg_ext_one) enable_reg_ext_one_reg <= SFR_WDATA;
      if (wr_enable_reg_ext_two) enable_reg_ext_two_reg <= SFR_WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ip_reg <= PRIORITY_RST;
      priority_reg_ext_one_reg <= PRIORITY_RST;
      priority_reg_ext_two_reg <= PRIORITY_RST;
      prio_written_reg <= 1'b0;
    end else begin
      if (wr_ip) ip_reg <= SFR_WDATA & ~PRIORITY_BASE_READ_ONE;
      if (wr_priority_reg_ext_one) priority_reg_ext_one_reg <= SFR_WDATA;
      if (wr_priority_reg_ext_two) priority_reg_ext_two_reg <= SFR_WDATA;
      if (wr_ip || wr_priority_reg_ext_one || wr_priority_reg_ext_two) prio_written_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External pins pass three flops; an edge counts once stages two and three agree.
  for (genvar p = 0; p < 2; p++) begin : g_pin
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        pin_sync_reg[p] <= 3'h7;
        pin_filt_reg[p] <= 1'b1;
      end else begin
        pin_sync_reg[p] <= {pin_sync_reg[p][1:0], (p == 0) ? EXT_PIN_ZERO_N : EXT_PIN_ONE_N};
        if (pin_sync_reg[p][1] == pin_sync_reg[p][2]) pin_filt_reg[p] <= pin_sync_reg[p][2];
      end
    end
    assign pin_fall[p] = pin_filt_reg[p] && !pin_sync_reg[p][1] && !pin_sync_reg[p][2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags: a set in the same cycle as any clear wins.
  // Timer 2 and serial requests are peripheral levels, so vectoring never clears them here.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_reg <= PEND_RST;
    end else begin
      logic [TLIPC_NSRC-1:0] nxt, set;
      nxt = pend_reg;
      set = SRC_EVENT;
      set[ORD_EXT_PIN_ZERO] = set[ORD_EXT_PIN_ZERO] | pin_fall[0];
      set[ORD_EXT_PIN_ONE] = set[ORD_EXT_PIN_ONE] | pin_fall[1];
      if (IRQ_ACK && HW_CLEAR_MASK[IRQ_ORDER]) nxt[IRQ_ORDER] = 1'b0;
      if (SFR_WR && SFR_ADDR == PEND_LOW_ADDR) nxt[7:0] = SFR_WDATA;
      if (SFR_WR && SFR_ADDR == PEND_MID_ADDR) nxt[15:8] = SFR_WDATA;
      if (SFR_WR && SFR_ADDR == PEND_TOP_ADDR) nxt[16] = SFR_WDATA[0];
      pend_reg <= (nxt | set) & SRC_PRESENT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration is combinational from this cycle's state, then registered.
  always_comb begin
    en_vec = map_bits(ie_reg, enable_reg_ext_one_reg, enable_reg_ext_two_reg);
    pr_vec = map_bits(ip_reg, priority_reg_ext_one_reg, priority_reg_ext_two_reg);
    req_vec = pend_reg;
    req_vec[ORD_TMR2] = pend_reg[ORD_TMR2] | TMR2_LOW_OVERFLOW | TMR2_HIGH_OVERFLOW;
    req_vec[ORD_SERIAL] = pend_reg[ORD_SERIAL] | SERIAL_XFER_DONE | WRITE_COLLISION
                          | MODE_FAULT | RECEIVE_OVERRUN;
    cand = gate ? (req_vec & en_vec) : '0;
    cand_hi = isr_hi_reg ? '0 : (cand & pr_vec);
    cand_lo = (isr_hi_reg || isr_lo_reg) ? '0 : (cand & ~pr_vec);
  end

  tlipc_arbiter #(.N(TLIPC_NSRC), .W(TLIPC_OW)) u_arb_hi (
    .req(cand_hi),
    .found(found_hi),
    .idx(idx_hi)
  );

  tlipc_arbiter #(.N(TLIPC_NSRC), .W(TLIPC_OW)) u_arb_lo (
    .req(cand_lo),
    .found(found_lo),
    .idx(idx_lo)
  );

  // The cycle of acceptance raises nothing, so a flag not yet cleared is not taken twice.
  assign sel_idx = found_hi ? idx_hi : idx_lo;
  // A return in progress refuses new requests too, so one instruction always runs first.
  assign req_next = (found_hi || found_lo) && !hold_reg && !RETURN_FROM_IRQ_DONE && !IRQ_ACK;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ_REQ <= 1'b0;
      IRQ_HIGH <= 1'b0;
      IRQ_ORDER <= '0;
      IRQ_VECTOR <= RESET_VECTOR;
    end else begin
      IRQ_REQ <= req_next;
      IRQ_HIGH <= found_hi;
      IRQ_ORDER <= sel_idx;
      IRQ_VECTOR <= VEC_BASE + {8'h00, sel_idx, 3'h0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service nesting: the core takes a request only at instruction end.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      isr_lo_reg <= 1'b0;
      isr_hi_reg <= 1'b0;
    end else if (IRQ_ACK && IRQ_REQ) begin
      if (IRQ_HIGH) isr_hi_reg <= 1'b1;
      else isr_lo_reg <= 1'b1;
    end else if (RETURN_FROM_IRQ_DONE) begin
      if (isr_hi_reg) isr_hi_reg <= 1'b0;
      else isr_lo_reg <= 1'b0;
    end
  end

  // A return blocks new requests until the next instruction has completed.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_reg <= 1'b0;
    end else if (RETURN_FROM_IRQ_DONE) begin
      hold_reg <= 1'b1;
    end else if (INSTR_DONE) begin
      hold_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; unmapped addresses read zero.
  always_comb begin
    case (SFR_ADDR)
      IRQ_ENABLE_MASK_ADDR: rdata_next = ie_reg;
      PRIORITY_REG_BASE_ADDR: rdata_next = ip_reg | PRIORITY_BASE_READ_ONE;
      ENABLE_REG_EXT_ONE_ADDR: rdata_next = enable_reg_ext_one_reg;
      PRIORITY_REG_EXT_ONE_ADDR: rdata_next = priority_reg_ext_one_reg;
      ENABLE_REG_EXT_TWO_ADDR: rdata_next = enable_reg_ext_two_reg;
      PRIORITY_REG_EXT_TWO_ADDR: rdata_next = priority_reg_ext_two_reg;
      PEND_LOW_ADDR: rdata_next = req_vec[7:0];
      PEND_MID_ADDR: rdata_next = req_vec[15:8];
      PEND_TOP_ADDR: rdata_next = {7'h00, req_vec[16]};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) SFR_RDATA <= 8'h00;
    else if (SFR_RD) SFR_RDATA <= rdata_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  hi_no_preempt_a: assert property (isr_hi_reg |=> !IRQ_REQ)
    else $error("Request raised during high-level service.");
  prio_reset_low_a: assert property (!prio_written_reg |-> pr_vec == '0)
    else $error("Priority not low after reset.");
  high_first_a: assert property ((found_hi && !hold_reg && !RETURN_FROM_IRQ_DONE && !IRQ_ACK)
      |=> IRQ_REQ && IRQ_HIGH)
    else $error("High-level request not chosen first.");
  lowest_order_a: assert property (IRQ_REQ |->
      (((IRQ_HIGH ? $past(cand_hi) : $past(cand_lo)) & below(IRQ_ORDER)) == '0))
    else $error("A lower order request was skipped.");
  // Reserved slots must never reach the core, whatever software writes to the flags.
  order_range_a: assert property (IRQ_REQ |-> SRC_PRESENT[IRQ_ORDER])
    else $error("Request names an empty order slot.");
  detect_one_a: assert property ((!isr_lo_reg && !isr_hi_reg && !hold_reg && !IRQ_ACK
      && !RETURN_FROM_IRQ_DONE && (|cand)) |=> IRQ_REQ)
    else $error("Request not raised one clock after detection.");
  return_from_irq_hold_a: assert property ($rose(hold_reg) |-> !IRQ_REQ [*2])
    else $error("Request raised before the instruction after return.");
  low_blocked_a: assert property (isr_lo_reg |=> !(IRQ_REQ && !IRQ_HIGH))
    else $error("Low-level request raised during low-level service.");
  sw_clear_a: assert property ((IRQ_ACK && IRQ_REQ && !HW_CLEAR_MASK[IRQ_ORDER]
      && pend_reg[IRQ_ORDER] && !SFR_WR) |=> pend_reg[$past(IRQ_ORDER)])
    else $error("Software-cleared flag changed on vectoring.");
  hw_clear_a: assert property ((IRQ_ACK && IRQ_REQ && HW_CLEAR_MASK[IRQ_ORDER]
      && SRC_EVENT == '0 && pin_fall == '0 && !SFR_WR) |=> !pend_reg[$past(IRQ_ORDER)])
    else $error("Pin or timer flag not cleared on vectoring.");
  serial_any_a: assert property ((SERIAL_XFER_DONE || WRITE_COLLISION || MODE_FAULT
      || RECEIVE_OVERRUN) |-> req_vec[ORD_SERIAL])
    else $error("Serial flag did not raise its request.");
  tmr2_level_a: assert property ((TMR2_LOW_OVERFLOW || TMR2_HIGH_OVERFLOW) |-> req_vec[ORD_TMR2])
    else $error("Timer 2 overflow did not raise its request.");
  pin_zero_set_a: assert property (pin_fall[0] |=> pend_reg[ORD_EXT_PIN_ZERO])
    else $error("Pin zero edge did not set its flag.");
  pin_one_set_a: assert property (pin_fall[1] |=> pend_reg[ORD_EXT_PIN_ONE])
    else $error("Pin one edge did not set its flag.");
  pend_set_a: assert property (SRC_EVENT[ORD_CONV_DONE] |=> pend_reg[ORD_CONV_DONE])
    else $error("Converter done event did not set its flag.");
  gate_off_a: assert property (!gate |=> !IRQ_REQ)
    else $error("Request raised with global gate closed.");
  vector_map_a: assert property (IRQ_REQ |-> IRQ_VECTOR == VEC_BASE + {8'h00, IRQ_ORDER, 3'h0})
    else $error("Vector does not match order.");

  preempt_c: cover property (isr_lo_reg && IRQ_REQ && IRQ_HIGH && IRQ_ACK);
  gate_open_c: cover property (!gate ##1 gate ##1 IRQ_REQ);
  reenter_c: cover property (RETURN_FROM_IRQ_DONE ##[1:4] INSTR_DONE ##[1:3] IRQ_REQ);
  simul_c: cover property (found_hi && found_lo && !hold_reg ##1 IRQ_REQ);
endmodule : tlipc_ctrl

// file: verilog/tlipc_pkg.sv
// Constants shared by the two-level interrupt priority controller.
package tlipc_pkg;
  localparam int unsigned TLIPC_NSRC = 17;
  localparam int unsigned TLIPC_OW = 5;
  // Special function register addresses.
  localparam logic [7:0] IRQ_ENABLE_MASK_ADDR = 8'hA8;
  localparam logic [7:0] PRIORITY_REG_BASE_ADDR = 8'hB8;
  localparam logic [7:0] ENABLE_REG_EXT_ONE_ADDR = 8'hC0;
  localparam logic [7:0] PRIORITY_REG_EXT_ONE_ADDR = 8'hC1;
  localparam logic [7:0] ENABLE_REG_EXT_TWO_ADDR = 8'hC2;
  localparam logic [7:0] PRIORITY_REG_EXT_TWO_ADDR = 8'hC3;
  localparam logic [7:0] PEND_LOW_ADDR = 8'hC4;
  localparam logic [7:0] PEND_MID_ADDR = 8'hC5;
  localparam logic [7:0] PEND_TOP_ADDR = 8'hC6;
  // Reset values and fixed read bits.
  localparam logic [7:0] IRQ_ENABLE_MASK_RST = 8'h00;
  localparam logic [7:0] PRIORITY_RST = 8'h00;
  localparam logic [7:0] PRIORITY_BASE_READ_ONE = 8'h80;
  localparam logic [16:0] PEND_RST = 17'h00000;
  // Field positions.
  localparam int unsigned GLOBAL_IRQ_GATE_BIT = 7;
  localparam int unsigned EXT2_PORT_MATCH_BIT = 1;
  // Fixed orders of sources.
  localparam logic [4:0] ORD_EXT_PIN_ZERO = 5'h00;
  localparam logic [4:0] ORD_EXT_PIN_ONE = 5'h02;
  localparam int unsigned ORD_TMR2 = 5;
  localparam int unsigned ORD_SERIAL = 6;
  localparam int unsigned ORD_CONV_WINDOW = 9;
  localparam int unsigned ORD_CONV_DONE = 10;
  localparam int unsigned ORD_PORT_MATCH = 16;
  // Slots 8 and 15 hold no source; orders 0 to 3 are cleared on vectoring.
  localparam logic [16:0] SRC_PRESENT = 17'h17EFF;
  localparam logic [16:0] HW_CLEAR_MASK = 17'h0000F;
  // Vector placement.
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int unsigned VEC_STEP = 8;
  // Response timing in system clocks.
  localparam int unsigned DETECT_CYC = 1;
  localparam int unsigned LONG_CALL_CYC = 4;
  localparam int unsigned MIN_RESPONSE_CYC = DETECT_CYC + LONG_CALL_CYC;
endpackage : tlipc_pkg

// file: verilog/tlipc_arbiter.sv
// Fixed-order arbiter that finds the lowest set request index.
`timescale 1ns/1ns
module tlipc_arbiter #(
  parameter int unsigned N = 17,
  parameter int unsigned W = 5
) (
  // Requests
  input wire logic [N-1:0] req,
  // Result
  output logic found,
  output logic [W-1:0] idx
);
  if (N > (1 << W)) begin : g_bad
    $error("Index width too small for request count.");
  end

  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = W'(i);
      end
    end
  end
endmodule : tlipc_arbiter

// file: bench/tlipc_core_model.sv
// Behavioural model of the core sequencer that answers the controller.
`timescale 1ns/1ns
module tlipc_core_model (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Controller side
  input wire logic IRQ_REQ,
  output logic INSTR_DONE = 1'h0,
  output logic IRQ_ACK = 1'h0,
  output logic RETURN_FROM_IRQ_DONE = 1'h0,
  // Bench control: slow stretches instructions, return_from_irq_req asks for a return
  input wire logic slow,
  input wire logic return_from_irq_req
);
  logic [2:0] cnt = 3'h0;
  logic pend = 1'h0;
  logic r;
  always @(posedge CLK) begin
    r = return_from_irq_req;
    #1;
    INSTR_DONE = 1'h0;
    IRQ_ACK = 1'h0;
    RETURN_FROM_IRQ_DONE = 1'h0;
    pend = pend | r;
    if (!RST_N) begin
      cnt = 3'h0;
      pend = 1'h0;
    end else if (cnt != 3'h0) begin
      cnt = cnt - 3'h1;
    end else if (pend) begin
      // A return ends on its own; the following instruction comes next.
      RETURN_FROM_IRQ_DONE = 1'h1;
      pend = 1'h0;
      cnt = slow ? 3'h2 : 3'h0;
    end else begin
      // Requests are only taken at the end of an instruction.
      INSTR_DONE = 1'h1;
      IRQ_ACK = IRQ_REQ;
      // The long call keeps the core busy for four clocks.
      cnt = IRQ_REQ ? 3'h4 : (slow ? 3'h2 : 3'h0);
    end
  end
endmodule : tlipc_core_model

// file: bench/tlipc_ctrl_tb.sv
// Self-checking bench for the two-level interrupt priority controller.
`timescale 1ns/1ns
module tlipc_ctrl_tb;
  import tlipc_pkg::*;
  logic CLK, RST_N, SFR_WR = 1'h0, SFR_RD = 1'h0, slow = 1'h0, return_from_irq_req = 1'h0;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA;
  logic [16:0] SRC_EVENT = 17'h00000;
  logic EXT_PIN_ZERO_N = 1'h1, EXT_PIN_ONE_N = 1'h1, T2L = 1'h0, T2H = 1'h0;
  logic [3:0] sp = 4'h0;
  logic INSTR_DONE, IRQ_ACK, RETURN_FROM_IRQ_DONE, IRQ_REQ, IRQ_HIGH;
  logic [4:0] IRQ_ORDER;
  logic [15:0] IRQ_VECTOR;
  logic [16:0] exp_q[$];
  logic [16:0] ve;
  logic [16:0] g;
  logic hi;
  int n_mismatch = 0, checks_done = 0, i;
  tlipc_ctrl u_tlipc_ctrl (.CLK(CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
    .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .SRC_EVENT(SRC_EVENT),
    .EXT_PIN_ZERO_N(EXT_PIN_ZERO_N), .EXT_PIN_ONE_N(EXT_PIN_ONE_N),
    .TMR2_LOW_OVERFLOW(T2L), .TMR2_HIGH_OVERFLOW(T2H), .SERIAL_XFER_DONE(sp[3]),
    .WRITE_COLLISION(sp[2]), .MODE_FAULT(sp[1]), .RECEIVE_OVERRUN(sp[0]),
    .INSTR_DONE(INSTR_DONE), .IRQ_ACK(IRQ_ACK), .RETURN_FROM_IRQ_DONE(RETURN_FROM_IRQ_DONE), .IRQ_REQ(IRQ_REQ),
    .IRQ_HIGH(IRQ_HIGH), .IRQ_ORDER(IRQ_ORDER), .IRQ_VECTOR(IRQ_VECTOR));
  tlipc_core_model u_tlipc_core_model (.CLK(CLK), .RST_N(RST_N), .IRQ_REQ(IRQ_REQ),
    .INSTR_DONE(INSTR_DONE), .IRQ_ACK(IRQ_ACK), .RETURN_FROM_IRQ_DONE(RETURN_FROM_IRQ_DONE), .slow(slow),
    .return_from_irq_req(return_from_irq_req));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [16:0] seen, logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : cyc
  task automatic wr(logic [7:0] a, logic [7:0] d);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1'h1;
    cyc(1);
    SFR_WR = 1'h0;
    cyc(1);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    SFR_ADDR = a;
    SFR_RD = 1'h1;
    cyc(1);
    SFR_RD = 1'h0;
    chk("register read", {9'h000, SFR_RDATA}, {9'h000, e});
    cyc(1);
  endtask : rd
  task automatic ev(logic [16:0] m);
    SRC_EVENT = m;
    cyc(1);
    SRC_EVENT = 17'h00000;
  endtask : ev
  // Waits until only n grants are still owed, under a bounded count.
  task automatic wack(int n);
    for (int k = 0; k < 60 && exp_q.size() > n; k++) cyc(1);
    chk("grants owed", 17'(exp_q.size()), 17'(n));
  endtask : wack
  task automatic return_from_irq();
    return_from_irq_req = 1'h1;
    cyc(1);
    return_from_irq_req = 1'h0;
    cyc(6);
  endtask : return_from_irq
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  // Every grant the core takes must match the oldest expected vector and level.
  always @(posedge CLK) begin
    if (IRQ_ACK === 1'h1) begin
      g = exp_q.size() != 0 ? exp_q.pop_front() : 17'h1FFFF;
      chk("grant", {IRQ_HIGH, IRQ_VECTOR}, g);
      chk("grant order", 17'(IRQ_ORDER), 17'((g[15:0] - VEC_BASE) >> 3));
    end
  end
  initial begin
    CLK = 1'h0;
    forever #25 CLK = ~CLK;
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  initial begin
    void'($urandom(32'h770B91C4));
    RST_N = 1'h0;
    cyc(6);
    RST_N = 1'h1;
    cyc(1);
    rd(IRQ_ENABLE_MASK_ADDR, 8'h00);
    rd(PRIORITY_REG_BASE_ADDR, 8'h80);
    rd(PRIORITY_REG_EXT_ONE_ADDR, 8'h00);
    rd(PRIORITY_REG_EXT_TWO_ADDR, 8'h00);
    rd(8'h90, 8'h00);
    // A closed gate keeps the flag pending until it opens.
    wr(IRQ_ENABLE_MASK_ADDR, 8'h02);
    ev(17'h00002);
    cyc(6);
    chk("gate closed", IRQ_REQ, 0);
    rd(PEND_LOW_ADDR, 8'h02);
    exp_q.push_back({1'h0, 16'h000B});
    wr(IRQ_ENABLE_MASK_ADDR, 8'h82);
    wack(0);
    return_from_irq();
    // Same-cycle pair: high wins, and low waits out the high routine.
    wr(IRQ_ENABLE_MASK_ADDR, 8'h8F);
    wr(PRIORITY_REG_BASE_ADDR, 8'h08);
    exp_q.push_back({1'h1, 16'h001B});
    exp_q.push_back({1'h0, 16'h000B});
    ev(17'h0000A);
    wack(1);
    cyc(8);
    chk("high not preempted", IRQ_REQ, 0);
    return_from_irq();
    wack(0);
    return_from_irq();
    // Same level: lower order first; raising the other to high then preempts.
    wr(PRIORITY_REG_BASE_ADDR, 8'h00);
    exp_q.push_back({1'h0, 16'h0003});
    ev(17'h00003);
    wack(0);
    cyc(6);
    chk("low held", IRQ_REQ, 0);
    exp_q.push_back({1'h1, 16'h000B});
    wr(PRIORITY_REG_BASE_ADDR, 8'h02);
    wack(0);
    return_from_irq();
    return_from_irq();
    // Every source once, with a random level and core pace.
    wr(IRQ_ENABLE_MASK_ADDR, 8'hFF);
    wr(ENABLE_REG_EXT_ONE_ADDR, 8'hFF);
    wr(ENABLE_REG_EXT_TWO_ADDR, 8'h02);
    for (i = 0; i < 17; i++) begin
      if (i == 8 || i == 15) continue;
      hi = 1'($urandom % 2);
      slow = 1'($urandom % 2);
      wr(PRIORITY_REG_BASE_ADDR, {8{hi}});
      wr(PRIORITY_REG_EXT_ONE_ADDR, {8{hi}});
      wr(PRIORITY_REG_EXT_TWO_ADDR, {8{hi}});
      ve = {hi, VEC_BASE + 16'(VEC_STEP * i)};
      exp_q.push_back(ve);
      case (i)
        0: EXT_PIN_ZERO_N = 1'h0;
        2: EXT_PIN_ONE_N = 1'h0;
        5: {T2H, T2L} = hi ? 2'h2 : 2'h1;
        6: sp = 4'h1 << ($urandom % 4);
        default: begin
          ev(17'h00001 << i);
          chk("request early", IRQ_REQ, 0);
          cyc(1);
          chk("request", IRQ_REQ, 1);
        end
      endcase
      wack(0);
      rd(PEND_LOW_ADDR + 8'(i / 8), i < 4 ? 8'h00 : 8'(1 << (i % 8)));
      if (i == 4) begin
        // A flag left set re-enters once the instruction after the return completes.
        exp_q.push_back(ve);
        return_from_irq();
        wack(0);
      end
      {EXT_PIN_ZERO_N, EXT_PIN_ONE_N, T2H, T2L, sp} = 8'hC0;
      wr(PEND_LOW_ADDR + 8'(i / 8), 8'h00);
      return_from_irq();
    end
    final_report();
  end
endmodule : tlipc_ctrl_tb
